// ---- logic/uctst_pkg.sv ----
package uctst_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_MASK = 8'h38;
    localparam logic [7:0] OFF_RAW  = 8'h3C;
    localparam logic [7:0] OFF_MSK  = 8'h40;
    localparam logic [7:0] OFF_ICLR = 8'h44;
    localparam logic [7:0] OFF_DMA  = 8'h48;
    localparam logic [7:0] OFF_TCTL = 8'h80;
    localparam logic [7:0] OFF_TIN  = 8'h84;
    localparam logic [7:0] OFF_TOUT = 8'h88;
    localparam logic [7:0] OFF_TDAT = 8'h8C;

    // widths
    localparam int IRQ_W  = 11;
    localparam int WORD_W = 11;
    localparam int TOUT_W = 12;

    // interrupt source bit positions
    localparam int B_OVR = 10;
    localparam int B_BRK = 9;
    localparam int B_PAR = 8;
    localparam int B_FRM = 7;
    localparam int B_RTO = 6;
    localparam int B_TX  = 5;
    localparam int B_RX  = 4;
    localparam int B_CTS = 1;

    // sticky sources cleared by write-one, level sources, all used bits
    localparam logic [IRQ_W-1:0] CLR_MASK  = 11'h7E0;
    localparam logic [IRQ_W-1:0] LVL_MASK  = 11'h012;
    localparam logic [IRQ_W-1:0] USED_MASK = 11'h7F2;

    // test control, test input and test output bit positions
    localparam int B_TFIFO = 1;
    localparam int B_ITEST = 0;
    localparam int B_TCTS  = 3;
    localparam int B_TRXD  = 0;
    localparam int B_TRTS  = 3;
    localparam int B_TTXD  = 0;
    localparam int B_TIRQ  = 6;

    // values after reset
    localparam logic [IRQ_W-1:0]  RST_MASK = 11'h000;
    localparam logic [IRQ_W-1:0]  RST_RAW  = 11'h000;
    localparam logic [1:0]        RST_TCTL = 2'h0;
    localparam logic [TOUT_W-1:0] RST_TOUT = 12'h000;
    localparam logic [31:0]       RST_DAT  = 32'h00000000;

    // interrupt outputs, in test output register order 11 down to 6
    typedef struct packed {
        logic modem;
        logic rx;
        logic tx;
        logic rt;
        logic err;
        logic comb;
    } uctst_irq_t;

    // serial pins driven out
    typedef struct packed {
        logic rts_n;
        logic txd;
    } uctst_pins_t;

endpackage : uctst_pkg

// ---- logic/uctst_top.sv ----
`timescale 1ns/100ps

// Function
// RULE1: writing one to bits 10..7 clears overrun, break, parity, framing sources
// RULE2: writing one to bit 6 clears the receive timeout source
// RULE3: writing one to bit 5 clears the transmit source
// RULE4: clear register bits 4 and 1 read masked receive and cts state
// RULE5: software writes zero to bits 3, 2, 0 and ignores their reads
// RULE6: dma control register ignores writes and reads zero
// RULE7: test fifo enable routes data writes to rx fifo, reads to tx fifo
// RULE8: without test fifo enable no direct fifo access, normal data path
// RULE9: test control bit 0 selects integration test mode
// RULE10: test input bits 3 and 0 read cts and rx data pin levels
// RULE11: test output bits 11..6 drive interrupt outputs through test mux
// RULE12: test output bits 3 and 0 drive rts and tx data pins
// RULE13: test data register bits 10:0 reach the fifos under test enable
// RULE14: software writes zero to reserved bits and ignores their reads
// RULE15: masked status is raw status gated by the mask
// RULE16: writing zero to a clear bit leaves the source unchanged
module uctst_top (
    // clock and reset
    input  wire logic                           CLK_I,
    input  wire logic                           RST_I,
    // wishbone classic slave
    input  wire logic                           CYC_I,
    input  wire logic                           STB_I,
    input  wire logic                           WE_I,
    input  wire logic [7:0]                     ADR_I,
    input  wire logic [3:0]                     SEL_I,
    input  wire logic [31:0]                    DAT_I,
    output wire logic [31:0]                    DAT_O,
    output wire logic                           ACK_O,
    // interrupt sources from the serial core
    input  wire logic [uctst_pkg::IRQ_W-1:0]    EVT_I,
    // serial pins
    input  wire logic                           RXD_I,
    input  wire logic                           CTS_N_I,
    output wire logic                           TXD_O,
    output wire logic                           RTS_N_O,
    // normal pin levels from the serial core, synced pins back to it
    input  wire logic                           TXD_NORM_I,
    input  wire logic                           RTS_N_NORM_I,
    output wire logic                           RXD_SYNC_O,
    output wire logic                           CTS_N_SYNC_O,
    // data port towards the fifos
    output wire logic                           TX_PUSH_O,
    output wire logic                           RX_POP_O,
    input  wire logic [uctst_pkg::WORD_W-1:0]   RX_DATA_I,
    output wire logic                           RXF_PUSH_O,
    output wire logic                           TXF_POP_O,
    input  wire logic [uctst_pkg::WORD_W-1:0]   TXF_DATA_I,
    output wire logic [uctst_pkg::WORD_W-1:0]   FIFO_WDATA_O,
    // interrupt outputs
    output wire uctst_pkg::uctst_irq_t          IRQ_LINES_O,
    output wire logic                           IRQ_O
);

    // byte enables widened to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : lane_mask

    logic                               ack_q;
    logic [31:0]                        dat_q;
    logic [uctst_pkg::WORD_W-1:0]       wdat_q;
    logic [uctst_pkg::IRQ_W-1:0]        sticky_q;
    logic [uctst_pkg::IRQ_W-1:0]        mask_q;
    logic [1:0]                         tctl_q;
    logic [uctst_pkg::TOUT_W-1:0]       tout_q;
    uctst_pkg::uctst_irq_t              irq_q;
    uctst_pkg::uctst_pins_t             pins_q;
    logic                               rxd_s1_q;
    logic                               rxd_s2_q;
    logic                               cts_s1_q;
    logic                               cts_s2_q;

    // bus handshake: answer one cycle after the request, effects at ack edge
    wire        req      = CYC_I & STB_I;
    wire        ack_d    = req & ~ack_q;
    wire        take     = req & ack_q;
    wire        wr       = take & WE_I;
    wire        rd       = take & ~WE_I;
    wire [31:0] wmask    = lane_mask(SEL_I);
    wire [31:0] wval     = DAT_I & wmask;

    // address decode
    wire hit_data = (ADR_I == uctst_pkg::OFF_DATA);
    wire hit_mask = (ADR_I == uctst_pkg::OFF_MASK);
    wire hit_raw  = (ADR_I == uctst_pkg::OFF_RAW);
    wire hit_msk  = (ADR_I == uctst_pkg::OFF_MSK);
    wire hit_iclr = (ADR_I == uctst_pkg::OFF_ICLR);
    wire hit_dma  = (ADR_I == uctst_pkg::OFF_DMA);
    wire hit_tctl = (ADR_I == uctst_pkg::OFF_TCTL);
    wire hit_tin  = (ADR_I == uctst_pkg::OFF_TIN);
    wire hit_tout = (ADR_I == uctst_pkg::OFF_TOUT);
    wire hit_tdat = (ADR_I == uctst_pkg::OFF_TDAT);

    // mode bits
    wire test_fifo_enable        = tctl_q[uctst_pkg::B_TFIFO];
    wire integration_test_enable = tctl_q[uctst_pkg::B_ITEST];

    // interrupt status: sticky sources plus level sources, then the mask
    wire [uctst_pkg::IRQ_W-1:0] raw_sts = (sticky_q & uctst_pkg::CLR_MASK)
                                        | (EVT_I & uctst_pkg::LVL_MASK);
    wire [uctst_pkg::IRQ_W-1:0] msk_sts = raw_sts & mask_q;   // [RULE15]
    wire [uctst_pkg::IRQ_W-1:0] clr_vec = (wr & hit_iclr)
                                        ? wval[uctst_pkg::IRQ_W-1:0] & uctst_pkg::CLR_MASK
                                        : '0;
    // set beats clear so an event in the clearing cycle survives
    wire [uctst_pkg::IRQ_W-1:0] sticky_d = (sticky_q & ~clr_vec)   // [RULE1] [RULE2] [RULE3] [RULE16]
                                         | (EVT_I & uctst_pkg::CLR_MASK);

    // normal interrupt outputs, then the test multiplexer
    uctst_pkg::uctst_irq_t irq_norm;
    assign irq_norm.modem = msk_sts[uctst_pkg::B_CTS];
    assign irq_norm.rx    = msk_sts[uctst_pkg::B_RX];
    assign irq_norm.tx    = msk_sts[uctst_pkg::B_TX];
    assign irq_norm.rt    = msk_sts[uctst_pkg::B_RTO];
    assign irq_norm.err   = |msk_sts[uctst_pkg::B_OVR:uctst_pkg::B_FRM];
    assign irq_norm.comb  = |msk_sts;
    wire uctst_pkg::uctst_irq_t irq_d = integration_test_enable   // [RULE9] [RULE11]
                                      ? uctst_pkg::uctst_irq_t'(tout_q[11:6])
                                      : irq_norm;

    // pin multiplexer: test output bits take over the pins in test mode
    // casts rather than patterns, a conditional gives a pattern no type
    wire uctst_pkg::uctst_pins_t pins_d = integration_test_enable   // [RULE12]
        ? uctst_pkg::uctst_pins_t'({tout_q[uctst_pkg::B_TRTS], tout_q[uctst_pkg::B_TTXD]})
        : uctst_pkg::uctst_pins_t'({RTS_N_NORM_I, TXD_NORM_I});

    // data port steering; the test data register is dead unless enabled
    wire data_sel = hit_data | (hit_tdat & test_fifo_enable);         // [RULE13]
    assign RXF_PUSH_O = wr & data_sel & test_fifo_enable;            // [RULE7]
    assign TXF_POP_O  = rd & data_sel & test_fifo_enable;            // [RULE7]
    assign TX_PUSH_O  = wr & hit_data & ~test_fifo_enable;           // [RULE8]
    assign RX_POP_O   = rd & hit_data & ~test_fifo_enable;           // [RULE8]

    // read data selection, captured when the request first appears
    wire [31:0] rd_fifo = test_fifo_enable ? {21'h000000, TXF_DATA_I}
                                           : {21'h000000, RX_DATA_I};
    wire [31:0] rd_iclr = {27'h0000000, msk_sts[uctst_pkg::B_RX], 2'h0,   // [RULE4]
                           msk_sts[uctst_pkg::B_CTS], 1'b0};
    wire [31:0] rd_tin  = {28'h0000000, cts_s2_q, 2'h0, rxd_s2_q};      // [RULE10]
    wire [31:0] rd_tout = {20'h00000, irq_q, 2'h0,                       // [RULE11]
                           tout_q[uctst_pkg::B_TRTS], 2'h0, tout_q[uctst_pkg::B_TTXD]};
    wire [31:0] rd_mux  = hit_data ? rd_fifo
                        : (hit_tdat & test_fifo_enable) ? rd_fifo
                        : hit_mask ? {21'h000000, mask_q}
                        : hit_raw  ? {21'h000000, raw_sts}
                        : hit_msk  ? {21'h000000, msk_sts}
                        : hit_iclr ? rd_iclr
                        : hit_tctl ? {30'h00000000, tctl_q}
                        : hit_tin  ? rd_tin
                        : hit_tout ? rd_tout
                        : 32'h00000000;   // dma control and unmapped read zero [RULE6]

    // bus slave registers
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ack_q  <= 1'b0;
            dat_q  <= uctst_pkg::RST_DAT;
            wdat_q <= '0;
        end else begin
            ack_q <= ack_d;
            if (ack_d & ~WE_I) dat_q  <= rd_mux;
            if (ack_d & WE_I)  wdat_q <= DAT_I[uctst_pkg::WORD_W-1:0];
        end
    end

    // software registers; dma control has no storage at all
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            mask_q <= uctst_pkg::RST_MASK;
            tctl_q <= uctst_pkg::RST_TCTL;
            tout_q <= uctst_pkg::RST_TOUT;
        end else if (wr) begin
            if (hit_mask) mask_q <= (mask_q & ~wmask[10:0]) | (wval[10:0] & uctst_pkg::USED_MASK);
            if (hit_tctl) tctl_q <= (tctl_q & ~wmask[1:0]) | wval[1:0];   // [RULE9]
            if (hit_tout) tout_q <= (tout_q & ~wmask[11:0]) | (wval[11:0] & 12'hFC9);
        end
    end

    // interrupt status and registered outputs
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            sticky_q <= uctst_pkg::RST_RAW;
            irq_q    <= '0;
            pins_q   <= '{rts_n: 1'b1, txd: 1'b1};
        end else begin
            sticky_q <= sticky_d;
            irq_q    <= irq_d;
            pins_q   <= pins_d;
        end
    end

    // two-stage synchronisers for the asynchronous pins
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rxd_s1_q <= 1'b1;
            rxd_s2_q <= 1'b1;
            cts_s1_q <= 1'b1;
            cts_s2_q <= 1'b1;
        end else begin
            rxd_s1_q <= RXD_I;
            rxd_s2_q <= rxd_s1_q;
            cts_s1_q <= CTS_N_I;
            cts_s2_q <= cts_s1_q;
        end
    end

    // outputs
    assign DAT_O        = dat_q;
    assign ACK_O        = ack_q;
    assign FIFO_WDATA_O = wdat_q;
    assign TXD_O        = pins_q.txd;
    assign RTS_N_O      = pins_q.rts_n;
    assign RXD_SYNC_O   = rxd_s2_q;
    assign CTS_N_SYNC_O = cts_s2_q;
    assign IRQ_LINES_O  = irq_q;
    assign IRQ_O        = irq_q.comb;

    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    property p_clr_ovr;
        wr && hit_iclr && DAT_I[10] && SEL_I[1] && !EVT_I[10] |=> !sticky_q[10];
    endproperty
    a_clr_ovr: assert property (p_clr_ovr) else $error("overrun not cleared"); // [RULE1]

    property p_clr_rto;
        wr && hit_iclr && DAT_I[6] && SEL_I[0] && !EVT_I[6] |=> !raw_sts[6];
    endproperty
    a_clr_rto: assert property (p_clr_rto) else $error("timeout not cleared"); // [RULE2]

    // irq lines are registered behind the status, so the drop shows two edges on
    property p_clr_tx;
        wr && hit_iclr && DAT_I[5] && SEL_I[0] && !EVT_I[5] && !integration_test_enable
            |-> ##2 !irq_q.tx;
    endproperty
    a_clr_tx: assert property (p_clr_tx) else $error("tx source not cleared"); // [RULE3]

    property p_keep_tx;
        wr && hit_iclr && !DAT_I[5] && sticky_q[5] |=> sticky_q[5];
    endproperty
    a_keep_tx: assert property (p_keep_tx) else $error("zero write cleared source"); // [RULE16]

    property p_iclr_rd;
        rd && hit_iclr |-> DAT_O[4] == $past(msk_sts[4]) && DAT_O[10:5] == 6'h00;
    endproperty
    a_iclr_rd: assert property (p_iclr_rd) else $error("clear register read wrong"); // [RULE4]

    property p_dma_zero;
        rd && hit_dma |-> DAT_O == 32'h00000000;
    endproperty
    a_dma_zero: assert property (p_dma_zero) else $error("dma control read nonzero"); // [RULE6]

    property p_tfifo_on;
        wr && hit_data && test_fifo_enable |-> RXF_PUSH_O && !TX_PUSH_O;
    endproperty
    a_tfifo_on: assert property (p_tfifo_on) else $error("test write missed rx fifo"); // [RULE7]

    property p_tfifo_off;
        !test_fifo_enable |-> !RXF_PUSH_O && !TXF_POP_O;
    endproperty
    a_tfifo_off: assert property (p_tfifo_off) else $error("direct fifo access"); // [RULE8]

    property p_tin_cts;
        rd && hit_tin |-> DAT_O[3] == $past(cts_s2_q) && DAT_O[0] == $past(rxd_s2_q);
    endproperty
    a_tin_cts: assert property (p_tin_cts) else $error("test input read wrong"); // [RULE10]

    property p_test_irq;
        integration_test_enable && $past(integration_test_enable)
            |-> irq_q == $past(tout_q[11:6]);
    endproperty
    a_test_irq: assert property (p_test_irq) else $error("test irq mux wrong"); // [RULE11]

    property p_test_pin;
        integration_test_enable && $past(integration_test_enable)
            |-> TXD_O == $past(tout_q[0]) && RTS_N_O == $past(tout_q[3]);
    endproperty
    a_test_pin: assert property (p_test_pin) else $error("test pin drive wrong"); // [RULE12]

    property p_norm_irq;
        !integration_test_enable && $past(!integration_test_enable)
            |-> IRQ_O == $past(|(raw_sts & mask_q));
    endproperty
    a_norm_irq: assert property (p_norm_irq) else $error("masked irq wrong"); // [RULE15]

    // an overrun event is never lost, even to a clear in the same cycle
    property p_ovr_set;
        EVT_I[uctst_pkg::B_OVR] |=> sticky_q[uctst_pkg::B_OVR];
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun event lost"); // [RULE1]

    // test data register stays dead while the test fifo path is off
    property p_tdat_off;
        rd && hit_tdat && !test_fifo_enable |-> DAT_O == 32'h00000000 && !TXF_POP_O;
    endproperty
    a_tdat_off: assert property (p_tdat_off) else $error("test data read leaked"); // [RULE8]

    c_clear:  cover property (wr && hit_iclr && sticky_q[10]);
    c_tpush:  cover property (RXF_PUSH_O && hit_tdat);
    c_tpop:   cover property (TXF_POP_O ##3 TXF_POP_O);
    c_itest:  cover property (integration_test_enable && IRQ_O);
    c_keep:   cover property (wr && hit_iclr && sticky_q[5] && !DAT_I[5]);

endmodule : uctst_top

// ---- test/uart_irq_clear_and_test_bench.sv ----
`timescale 1ns/100ps

module uart_irq_clear_and_test_bench;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, rxl = 1, ctl = 1, tn = 1, rn = 1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rdv, q, v;
    logic [10:0] evt = 11'h000, txh, rxh;
    wire logic [31:0] dat;
    wire logic ack, txd, rts_n, rxd, cts_n, txp, rxp, rxfp, txfp, irq;
    wire logic [10:0] fwd;
    wire logic rxs, ctss;
    logic [3:0] sel = 4'hF;
    logic [7:0] zregs [6] = '{8'h44, 8'h48, 8'h80, 8'h88, 8'h8C, 8'hF0};
    wire uctst_pkg::uctst_irq_t lines;
    logic sp_tx, sp_rx, sp_rxf, sp_txf;
    logic [10:0] sp_wd;
    logic [31:0] seed = 32'hCB1F8D28;
    int n_mismatch = 0, num_checks = 0;

    // clock and far side
    always #5 clk = ~clk;
    uctst_far far_u (.clk_i(clk), .pop_tx_i(txfp), .pop_rx_i(rxp), .rxd_lvl_i(rxl),
        .cts_lvl_i(ctl), .rxd_o(rxd), .cts_n_o(cts_n), .txf_head_o(txh), .rx_head_o(rxh));
    uctst_top dut_u (.CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(wd), .DAT_O(dat), .ACK_O(ack), .EVT_I(evt),
        .RXD_I(rxd), .CTS_N_I(cts_n), .TXD_O(txd), .RTS_N_O(rts_n), .TXD_NORM_I(tn),
        .RTS_N_NORM_I(rn), .RXD_SYNC_O(rxs), .CTS_N_SYNC_O(ctss), .TX_PUSH_O(txp),
        .RX_POP_O(rxp), .RX_DATA_I(rxh), .RXF_PUSH_O(rxfp), .TXF_POP_O(txfp),
        .TXF_DATA_I(txh), .FIFO_WDATA_O(fwd), .IRQ_LINES_O(lines), .IRQ_O(irq));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // one classic cycle; values read right after an edge are those the edge saw,
    // so the ack edge is where data and strobes are taken and the request drops
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk(1'b0, 1'b1);
        {rdv, sp_tx, sp_rx, sp_rxf, sp_txf, sp_wd} = {dat, txp, rxp, rxfp, txfp, fwd};
        {cyc, stb} <= 2'b00;
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask : rd_chk

    // watchdog, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // register reset values and pins
        foreach (zregs[i])
            rd_chk(zregs[i], 32'h0);
        chk({txd, rts_n}, 2'b11);
        // sticky sources: set, zero write keeps, one write clears
        for (int b = 5; b <= 10; b++) begin
            v = rnd() & 32'h7F2;
            bus(1'b1, 8'h38, v | (32'h1 << b));
            @(posedge clk) evt <= 11'h001 << b;
            @(posedge clk) evt <= 11'h000;
            rd_chk(8'h3C, 32'h1 << b);
            bus(1'b1, 8'h44, (rnd() & 32'h7E0) & ~(32'h1 << b));
            rd_chk(8'h3C, 32'h1 << b);
            bus(1'b1, 8'h38, v);
            rd_chk(8'h40, v & (32'h1 << b));
            chk(irq, v[b]);
            chk(lines, {2'b00, b == 5, b == 6, b > 6, 1'b1} & {6{v[b]}});
            bus(1'b1, 8'h44, 32'h1 << b);
            rd_chk(8'h3C, 32'h0);
            chk(irq, 1'b0);
        end
        // level sources read back through the clear register
        @(posedge clk) evt <= 11'h012;
        bus(1'b1, 8'h38, 32'h7F2);
        rd_chk(8'h44, 32'h12);
        chk(lines, 6'h31);
        bus(1'b1, 8'h38, 32'h010);
        rd_chk(8'h44, 32'h10);
        // only the low byte lane is written, the upper mask bits keep their zeros
        sel <= 4'h1;
        bus(1'b1, 8'h38, 32'h7F2);
        sel <= 4'hF;
        rd_chk(8'h38, 32'h0F2);
        @(posedge clk) evt <= 11'h000;
        bus(1'b1, 8'h48, rnd());
        rd_chk(8'h48, 32'h0);
        // integration test mode drives pins and irq lines from the register
        bus(1'b1, 8'h80, 32'h1);
        rd_chk(8'h80, 32'h1);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 32'hFC9 : (i == 1) ? 32'h0 : rnd() & 32'hFC9;
            bus(1'b1, 8'h88, v);
            repeat (3) @(posedge clk);
            chk(lines, v[11:6]);
            chk({rts_n, txd}, {v[3], v[0]});
            rd_chk(8'h88, v);
            {rxl, ctl} <= 2'(rnd());
            repeat (5) @(posedge clk);
            rd_chk(8'h84, {ctl, 2'b00, rxl});
            chk({ctss, rxs}, {ctl, rxl});
        end
        bus(1'b1, 8'h80, 32'h0);
        {tn, rn} <= 2'b01;
        repeat (3) @(posedge clk);
        chk({txd, rts_n}, 2'b01);
        // test fifo path on, then off
        bus(1'b1, 8'h80, 32'h2);
        for (int i = 0; i < 2; i++) begin
            v = rnd() & 32'h7FF;
            bus(1'b1, i ? 8'h00 : 8'h8C, v);
            chk({sp_rxf, sp_tx, sp_wd}, {2'b10, v[10:0]});
            q = txh;
            rd_chk(i ? 8'h00 : 8'h8C, q);
            chk({sp_txf, sp_rx}, 2'b10);
        end
        bus(1'b1, 8'h80, 32'h0);
        bus(1'b1, 8'h8C, 32'h155);
        chk(sp_rxf, 1'b0);
        rd_chk(8'h8C, 32'h0);
        chk(sp_txf, 1'b0);
        bus(1'b1, 8'h00, 32'h0AA);
        chk({sp_tx, sp_rxf}, 2'b10);
        q = rxh;
        rd_chk(8'h00, q);
        chk({sp_rx, sp_txf}, 2'b10);
        wrap_up();
    end
endmodule : uart_irq_clear_and_test_bench

// ---- test/uctst_far.sv ----
`timescale 1ns/100ps

// far side: serial peer levels and fifo heads behind the data port
module uctst_far (
    // clock
    input  wire logic        clk_i,
    // pops from the block, levels from the bench
    input  wire logic        pop_tx_i,
    input  wire logic        pop_rx_i,
    input  wire logic        rxd_lvl_i,
    input  wire logic        cts_lvl_i,
    // pins and fifo heads
    output wire logic        rxd_o,
    output wire logic        cts_n_o,
    output logic      [10:0] txf_head_o,
    output logic      [10:0] rx_head_o
);
    // peer holds its pins at the commanded level
    assign rxd_o   = rxd_lvl_i;
    assign cts_n_o = cts_lvl_i;
    // heads step on each pop, so a read that never pops is seen
    initial begin
        txf_head_o = 11'h5A3;
        rx_head_o  = 11'h1C6;
    end
    always @(posedge clk_i) begin
        if (pop_tx_i) txf_head_o <= txf_head_o + 11'h001;
        if (pop_rx_i) rx_head_o <= rx_head_o - 11'h001;
    end
endmodule : uctst_far
